/* hdl/phy_rst_pkg.sv */
package phy_rst_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 200;
  localparam int DEGLITCH_TIME_NS = 1000;
  localparam int DEGLITCH_CYC = (DEGLITCH_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SHORT_RST_TIME_NS = 1200;
  localparam int SHORT_RST_CYC = (SHORT_RST_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int HW_RELEASE_TIME_MS = 50;
  localparam int HW_RELEASE_CYC = HW_RELEASE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int SW_RELEASE_TIME_MS = 10;
  localparam int SW_RELEASE_CYC = SW_RELEASE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int REF_HW_HOLD_TIME_MS = 70;
  localparam int REF_HW_HOLD_CYC = REF_HW_HOLD_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int REF_SW_HOLD_TIME_MS = 25;
  localparam int REF_SW_HOLD_CYC = REF_SW_HOLD_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int STRAP_W = 5;
  localparam int SYS_ERR_W = 4;
  localparam int SYNC_W = STRAP_W + 3;
  localparam int SYNC_PG_POS = 0;
  localparam int SYNC_OSC_POS = 1;
  localparam int SYNC_PLL_POS = 2;
  localparam int SYNC_STRAP_POS = 3;
  localparam int ELAPSED_W = 24;
  localparam int SHORT_CNT_W = 8;
  localparam int FILT_CNT_W = 8;
  localparam int NUM_SHORT = 2;
  localparam int SHORT_PHY = 0;
  localparam int SHORT_MAC = 1;
  localparam logic [STRAP_W-1:0] STRAP_RST = 5'h00;
  localparam logic [SYS_ERR_W-1:0] SYS_ERR_RST = 4'h0;
  localparam logic [ELAPSED_W-1:0] ELAPSED_RST = 24'h00_0000;
  localparam logic [SHORT_CNT_W-1:0] SHORT_CNT_RST = 8'h00;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Start-up sequence states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_PWRDN  = 8'h01,
    S_TRI    = 8'h02,
    S_LATCH  = 8'h04,
    S_FUNC   = 8'h08,
    S_SUPPLY = 8'h10,
    S_OSC    = 8'h20,
    S_PLL    = 8'h40,
    S_RUN    = 8'h80
  } seq_state_t;

endpackage

/* hdl/pin_filter_if.sv */
`timescale 1ns/1ps
interface pin_filter_if;
  logic held_low;
  modport producer (output held_low);
  modport consumer (input held_low);
endinterface

/* hdl/reset_pin_filter.sv */
`timescale 1ns/1ps
module reset_pin_filter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  pin_filter_if.producer flt
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Low-time filter
  // ----------------------------------------------------------------
  logic [phy_rst_pkg::FILT_CNT_W-1:0] low_cnt_reg;
  logic [phy_rst_pkg::FILT_CNT_W-1:0] low_cnt_next;
  logic held_low_reg;
  logic held_low_next;
  localparam logic [phy_rst_pkg::FILT_CNT_W-1:0] FILT_LIMIT =
    phy_rst_pkg::FILT_CNT_W'(phy_rst_pkg::DEGLITCH_CYC);

  always_comb begin
    low_cnt_next = phy_rst_pkg::FILT_CNT_RST;
    if (!pin_sync_reg) begin
      low_cnt_next = (low_cnt_reg == FILT_LIMIT) ? low_cnt_reg : low_cnt_reg + 8'h01; // [RULE6]
    end
    held_low_next = !pin_sync_reg && (low_cnt_next == FILT_LIMIT); // [RULE6]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_reg <= phy_rst_pkg::FILT_CNT_RST;
      held_low_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      held_low_reg <= held_low_next;
    end
  end

  assign flt.held_low = held_low_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_glitch_reject: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
    $rose(held_low_reg) |-> $past(low_cnt_reg) == FILT_LIMIT - 8'h01 && !$past(pin_sync_reg))
    else $error("reset pin accepted before the low time elapsed");

endmodule

/* hdl/phy_reset_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1: System error flags are sticky; only a hardware reset clears them.
// RULE2: Host sets matching enable bits before errors may raise the interrupt.
// RULE3: MAC-side output pins are driven low whenever the core is in reset.
// RULE4: At power-up stay in hardware reset until power is good.
// RULE5: Host holds the reset pin low for at least ten microseconds.
// RULE6: Reset pin lows shorter than one microsecond are filtered out.
// RULE7: On pin release: tristate, latch straps, then enable functional pins.
// RULE8: Oscillator starts after supplies are good; PLL after oscillator settles.
// RULE9: Logic released and registers accessible within 50 ms of pin release.
// RULE10: Reference clock held low during pin reset and at most 70 ms after.
// RULE11: Software reset repeats the hardware sequence without supply validation.
// RULE12: Software reset tristates, relatches straps, restarts oscillator then PLL.
// RULE13: Logic released within 10 ms after the software reset bit is set.
// RULE14: System-ready flag set once the start-up sequence has finished.
// RULE15: Reference clock low at most 25 ms after a software reset.
// RULE16: PHY core reset bit resets PHY logic for 1.2 us, then self-clears.
// RULE17: PHY core reset keeps register contents and access throughout.
// RULE18: MAC-side reset bit resets only MAC interface for 1.2 us, self-clears.
// RULE19: MAC-side reset aborts frames but keeps link and register values.
// RULE20: While reset pin is low: clocks gated, pins tristated, no register access.
// RULE21: Software reset bit reads zero once its reinitialisation completes.
module phy_reset_sequencer #(
  parameter int HW_RELEASE_CYC = phy_rst_pkg::HW_RELEASE_CYC,
  parameter int SW_RELEASE_CYC = phy_rst_pkg::SW_RELEASE_CYC,
  parameter int REF_HW_HOLD_CYC = phy_rst_pkg::REF_HW_HOLD_CYC,
  parameter int REF_SW_HOLD_CYC = phy_rst_pkg::REF_SW_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic power_good,
  input wire logic osc_stable,
  input wire logic pll_locked,
  input wire logic [phy_rst_pkg::STRAP_W-1:0] strap_pins,
  input wire logic soft_reset_wr,
  input wire logic phy_core_reset_wr,
  input wire logic mac_side_reset_wr,
  input wire logic [phy_rst_pkg::SYS_ERR_W-1:0] sys_err_events,
  input wire logic [phy_rst_pkg::SYS_ERR_W-1:0] system_irq_enables,
  output logic io_oe,
  output logic [phy_rst_pkg::STRAP_W-1:0] strap_latched,
  output logic clocks_gated,
  output logic osc_enable,
  output logic pll_enable,
  output logic logic_reset_n,
  output logic regs_accessible,
  output logic ref_clock_out_en,
  output logic mac_pins_low,
  output logic chip_soft_reset_bit,
  output logic phy_core_reset_bit,
  output logic mac_side_reset_bit,
  output logic system_ready_flag,
  output logic [phy_rst_pkg::SYS_ERR_W-1:0] system_irq_flags,
  output logic sys_err_irq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_boot(input phy_rst_pkg::seq_state_t s);
    in_boot = (s != phy_rst_pkg::S_PWRDN) && (s != phy_rst_pkg::S_RUN);
  endfunction

  function automatic logic pins_functional(input phy_rst_pkg::seq_state_t s);
    pins_functional = (s == phy_rst_pkg::S_FUNC) || (s == phy_rst_pkg::S_SUPPLY) ||
                      (s == phy_rst_pkg::S_OSC) || (s == phy_rst_pkg::S_PLL) ||
                      (s == phy_rst_pkg::S_RUN);
  endfunction

  function automatic logic osc_on(input phy_rst_pkg::seq_state_t s);
    osc_on = (s == phy_rst_pkg::S_OSC) || (s == phy_rst_pkg::S_PLL) ||
             (s == phy_rst_pkg::S_RUN);
  endfunction

  // ----------------------------------------------------------------
  // Reset pin filter
  // ----------------------------------------------------------------
  pin_filter_if pin_flt ();

  reset_pin_filter u_pin_filter (
    .clk(clk),
    .rstn(rstn),
    .reset_pin_n(reset_pin_n),
    .flt(pin_flt.producer)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [phy_rst_pkg::SYNC_W-1:0] meta_reg;
  logic [phy_rst_pkg::SYNC_W-1:0] sync_reg;
  logic pg_s;
  logic osc_s;
  logic pll_s;
  logic [phy_rst_pkg::STRAP_W-1:0] strap_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {strap_pins, pll_locked, osc_stable, power_good};
      sync_reg <= meta_reg;
    end
  end

  assign pg_s = sync_reg[phy_rst_pkg::SYNC_PG_POS];
  assign osc_s = sync_reg[phy_rst_pkg::SYNC_OSC_POS];
  assign pll_s = sync_reg[phy_rst_pkg::SYNC_PLL_POS];
  assign strap_s = sync_reg[phy_rst_pkg::SYNC_STRAP_POS +: phy_rst_pkg::STRAP_W];

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  phy_rst_pkg::seq_state_t state_reg;
  phy_rst_pkg::seq_state_t state_next;
  logic soft_mode_reg;
  logic soft_mode_next;
  logic [phy_rst_pkg::ELAPSED_W-1:0] elapsed_reg;
  logic [phy_rst_pkg::ELAPSED_W-1:0] elapsed_next;
  logic [phy_rst_pkg::ELAPSED_W-1:0] release_limit;
  logic [phy_rst_pkg::STRAP_W-1:0] strap_next;

  assign release_limit = soft_mode_reg ? phy_rst_pkg::ELAPSED_W'(SW_RELEASE_CYC) :
                                         phy_rst_pkg::ELAPSED_W'(HW_RELEASE_CYC);

  always_comb begin
    state_next = state_reg;
    soft_mode_next = soft_mode_reg;
    strap_next = strap_latched;
    elapsed_next = elapsed_reg;
    if (in_boot(state_reg) && (elapsed_reg != '1)) begin
      elapsed_next = elapsed_reg + 24'h00_0001;
    end
    if (pin_flt.held_low) begin
      state_next = phy_rst_pkg::S_PWRDN; // [RULE20]
      soft_mode_next = 1'b0;
      elapsed_next = phy_rst_pkg::ELAPSED_RST;
    end else begin
      unique case (state_reg)
        phy_rst_pkg::S_PWRDN: begin
          state_next = phy_rst_pkg::S_TRI; // [RULE7]
          elapsed_next = phy_rst_pkg::ELAPSED_RST;
        end
        phy_rst_pkg::S_TRI: begin
          state_next = phy_rst_pkg::S_LATCH; // [RULE7] [RULE12]
        end
        phy_rst_pkg::S_LATCH: begin
          strap_next = strap_s; // [RULE7] [RULE12]
          state_next = phy_rst_pkg::S_FUNC;
        end
        phy_rst_pkg::S_FUNC: begin
          state_next = soft_mode_reg ? phy_rst_pkg::S_OSC : phy_rst_pkg::S_SUPPLY; // [RULE11]
        end
        phy_rst_pkg::S_SUPPLY: begin
          state_next = pg_s ? phy_rst_pkg::S_OSC : phy_rst_pkg::S_SUPPLY; // [RULE4] [RULE8]
          // Deadline counts from good supplies, never skips them
          elapsed_next = pg_s ? elapsed_next : phy_rst_pkg::ELAPSED_RST; // [RULE4]
        end
        phy_rst_pkg::S_OSC: begin
          if (osc_s) begin
            state_next = phy_rst_pkg::S_PLL; // [RULE8] [RULE12]
          end
        end
        phy_rst_pkg::S_PLL: begin
          if (pll_s) begin
            state_next = phy_rst_pkg::S_RUN;
          end
        end
        phy_rst_pkg::S_RUN: begin
          if (soft_reset_wr) begin
            state_next = phy_rst_pkg::S_TRI; // [RULE11] [RULE12]
            soft_mode_next = 1'b1;
            elapsed_next = phy_rst_pkg::ELAPSED_RST;
          end
        end
        default: begin
          state_next = phy_rst_pkg::S_PWRDN;
        end
      endcase
      if (in_boot(state_reg) && (elapsed_reg >= release_limit)) begin
        state_next = phy_rst_pkg::S_RUN; // [RULE9] [RULE13]
      end
      if (state_next == phy_rst_pkg::S_RUN) begin
        soft_mode_next = 1'b0; // [RULE21]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= phy_rst_pkg::S_PWRDN; // [RULE4]
      soft_mode_reg <= 1'b0;
      elapsed_reg <= phy_rst_pkg::ELAPSED_RST;
    end else begin
      state_reg <= state_next;
      soft_mode_reg <= soft_mode_next;
      elapsed_reg <= elapsed_next;
    end
  end

  // ----------------------------------------------------------------
  // Short self-clearing resets
  // ----------------------------------------------------------------
  logic [phy_rst_pkg::SHORT_CNT_W-1:0] sr_cnt_reg [phy_rst_pkg::NUM_SHORT];
  logic [phy_rst_pkg::SHORT_CNT_W-1:0] sr_cnt_next [phy_rst_pkg::NUM_SHORT];
  logic [phy_rst_pkg::NUM_SHORT-1:0] sr_wr;
  logic [phy_rst_pkg::NUM_SHORT-1:0] sr_busy_next;

  assign sr_wr[phy_rst_pkg::SHORT_PHY] = phy_core_reset_wr;
  assign sr_wr[phy_rst_pkg::SHORT_MAC] = mac_side_reset_wr;

  for (genvar i = 0; i < phy_rst_pkg::NUM_SHORT; i++) begin : g_short
    always_comb begin
      sr_cnt_next[i] = phy_rst_pkg::SHORT_CNT_RST;
      if (state_next == phy_rst_pkg::S_RUN) begin
        if (sr_cnt_reg[i] != phy_rst_pkg::SHORT_CNT_RST) begin
          sr_cnt_next[i] = sr_cnt_reg[i] - 8'h01; // [RULE16] [RULE18]
        end else if (sr_wr[i] && (state_reg == phy_rst_pkg::S_RUN)) begin
          sr_cnt_next[i] = phy_rst_pkg::SHORT_CNT_W'(phy_rst_pkg::SHORT_RST_CYC);
        end
      end
      sr_busy_next[i] = sr_cnt_next[i] != phy_rst_pkg::SHORT_CNT_RST;
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        sr_cnt_reg[i] <= phy_rst_pkg::SHORT_CNT_RST;
      end else begin
        sr_cnt_reg[i] <= sr_cnt_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // System error flags
  // ----------------------------------------------------------------
  logic [phy_rst_pkg::SYS_ERR_W-1:0] flags_next;
  logic irq_next;

  always_comb begin
    flags_next = system_irq_flags | sys_err_events; // [RULE1]
    if (pin_flt.held_low) begin
      flags_next = phy_rst_pkg::SYS_ERR_RST; // [RULE1]
    end
    irq_next = |(flags_next & system_irq_enables); // [RULE2]
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic run_next;

  assign run_next = state_next == phy_rst_pkg::S_RUN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_oe <= 1'b0;
      strap_latched <= phy_rst_pkg::STRAP_RST;
      clocks_gated <= 1'b1;
      osc_enable <= 1'b0;
      pll_enable <= 1'b0;
      logic_reset_n <= 1'b0;
      regs_accessible <= 1'b0;
      ref_clock_out_en <= 1'b0;
      mac_pins_low <= 1'b1;
      chip_soft_reset_bit <= 1'b0;
      phy_core_reset_bit <= 1'b0;
      mac_side_reset_bit <= 1'b0;
      system_ready_flag <= 1'b0;
      system_irq_flags <= phy_rst_pkg::SYS_ERR_RST;
      sys_err_irq <= 1'b0;
    end else begin
      io_oe <= pins_functional(state_next); // [RULE7] [RULE20]
      strap_latched <= strap_next;
      clocks_gated <= state_next == phy_rst_pkg::S_PWRDN; // [RULE20]
      osc_enable <= osc_on(state_next); // [RULE8]
      pll_enable <= (state_next == phy_rst_pkg::S_PLL) || run_next; // [RULE8]
      logic_reset_n <= run_next; // [RULE9] [RULE13]
      regs_accessible <= run_next; // [RULE17] [RULE19]
      ref_clock_out_en <= run_next; // [RULE10] [RULE15]
      mac_pins_low <= !run_next || (|sr_busy_next); // [RULE3] [RULE19]
      chip_soft_reset_bit <= soft_mode_next; // [RULE21]
      phy_core_reset_bit <= sr_busy_next[phy_rst_pkg::SHORT_PHY]; // [RULE16] [RULE17]
      mac_side_reset_bit <= sr_busy_next[phy_rst_pkg::SHORT_MAC]; // [RULE18] [RULE19]
      system_ready_flag <= run_next; // [RULE14]
      system_irq_flags <= flags_next;
      sys_err_irq <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_flags_sticky: assert property ( // [RULE1]
    !pin_flt.held_low |=> (system_irq_flags & $past(system_irq_flags)) == $past(system_irq_flags))
    else $error("system error flag cleared without hardware reset");

  a_mac_low_reset: assert property ( // [RULE3]
    (!logic_reset_n || phy_core_reset_bit || mac_side_reset_bit) |-> mac_pins_low)
    else $error("MAC pins not low while core in reset");

  a_supply_first: assert property ( // [RULE4]
    $rose(osc_enable) && state_reg == phy_rst_pkg::S_OSC && !soft_mode_reg |-> $past(pg_s))
    else $error("oscillator enabled before power good");

  a_strap_latch: assert property ( // [RULE7]
    state_reg == phy_rst_pkg::S_LATCH |-> !io_oe ##1 strap_latched == $past(strap_s))
    else $error("straps not latched while pins tristated");

  a_pll_after_osc: assert property ( // [RULE8]
    $rose(pll_enable) && state_reg == phy_rst_pkg::S_PLL |-> $past(osc_s) && $past(osc_enable))
    else $error("PLL enabled before oscillator stable");

  a_hw_deadline: assert property ( // [RULE9]
    !soft_mode_reg && in_boot(state_reg) && !pin_flt.held_low &&
    elapsed_reg == phy_rst_pkg::ELAPSED_W'(HW_RELEASE_CYC) |=> logic_reset_n && regs_accessible)
    else $error("logic not released by hardware reset deadline");

  a_ref_hw_low: assert property ( // [RULE10]
    (clocks_gated |-> !ref_clock_out_en) and
    (!soft_mode_reg && elapsed_reg >= phy_rst_pkg::ELAPSED_W'(REF_HW_HOLD_CYC) |->
     ref_clock_out_en || clocks_gated))
    else $error("reference clock hold violated after hardware reset");

  a_soft_skip: assert property ( // [RULE11]
    state_reg == phy_rst_pkg::S_FUNC && soft_mode_reg && !pin_flt.held_low |=>
    state_reg != phy_rst_pkg::S_SUPPLY)
    else $error("software reset waited for supplies");

  a_soft_deadline: assert property ( // [RULE13]
    soft_mode_reg && in_boot(state_reg) && !pin_flt.held_low &&
    elapsed_reg == phy_rst_pkg::ELAPSED_W'(SW_RELEASE_CYC) |=> logic_reset_n)
    else $error("logic not released by software reset deadline");

  a_ready_flag: assert property ( // [RULE14]
    system_ready_flag == (state_reg == phy_rst_pkg::S_RUN))
    else $error("system ready flag does not match sequence");

  a_ref_sw_low: assert property ( // [RULE15]
    soft_mode_reg && elapsed_reg >= phy_rst_pkg::ELAPSED_W'(REF_SW_HOLD_CYC) |-> ref_clock_out_en)
    else $error("reference clock held too long after software reset");

  a_phy_pulse: assert property ( // [RULE16]
    $rose(phy_core_reset_bit) |-> ##239 (phy_core_reset_bit || !system_ready_flag)
    ##1 !phy_core_reset_bit)
    else $error("PHY core reset pulse length wrong");

  a_phy_keeps_regs: assert property ( // [RULE17]
    phy_core_reset_bit |-> regs_accessible && logic_reset_n)
    else $error("PHY core reset dropped register access");

  a_mac_pulse: assert property ( // [RULE18]
    $rose(mac_side_reset_bit) |-> ##239 (mac_side_reset_bit || !system_ready_flag)
    ##1 !mac_side_reset_bit)
    else $error("MAC-side reset pulse length wrong");

  a_mac_keeps_link: assert property ( // [RULE19]
    mac_side_reset_bit |-> regs_accessible && mac_pins_low && system_ready_flag)
    else $error("MAC-side reset disturbed the core");

  a_pwrdn_state: assert property ( // [RULE20]
    pin_flt.held_low |=> clocks_gated && !io_oe && !regs_accessible && !osc_enable)
    else $error("power-down state not entered while pin low");

  a_soft_bit_clear: assert property ( // [RULE21]
    $fell(chip_soft_reset_bit) |-> system_ready_flag || clocks_gated)
    else $error("software reset bit cleared before completion");

endmodule

/* verification/clock_source_model.sv */
`timescale 1ns/1ps
module clock_source_model #(
  parameter int OSC_DLY = 20,
  parameter int PLL_DLY = 10
) (
  input wire logic clk,
  input wire logic osc_enable,
  input wire logic pll_enable,
  output logic osc_stable,
  output logic pll_locked
);
  int osc_cnt = 0;
  int pll_cnt = 0;
  // ----------------------------------------------------------------
  // Crystal settles some cycles after enable; PLL locks after it
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    osc_cnt <= osc_enable ? osc_cnt + 1 : 0;
    pll_cnt <= pll_enable ? pll_cnt + 1 : 0;
  end
  assign osc_stable = osc_enable && (osc_cnt >= OSC_DLY);
  assign pll_locked = pll_enable && osc_stable && (pll_cnt >= PLL_DLY);
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int HW_REL = 2000;
  localparam int SW_REL = 500;
  localparam int REF_HW = 2800;
  localparam int REF_SW = 1000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reset_pin_n = 1'b1;
  logic power_good = 1'b0;
  logic osc_stable, pll_locked;
  logic [phy_rst_pkg::STRAP_W-1:0] strap_pins = 5'h0A;
  logic soft_reset_wr = 1'b0;
  logic phy_core_reset_wr = 1'b0;
  logic mac_side_reset_wr = 1'b0;
  logic [phy_rst_pkg::SYS_ERR_W-1:0] sys_err_events = 4'h0;
  logic [phy_rst_pkg::SYS_ERR_W-1:0] system_irq_enables = 4'h0;
  logic io_oe, clocks_gated, osc_enable, pll_enable, logic_reset_n, regs_accessible;
  logic ref_clock_out_en, mac_pins_low, chip_soft_reset_bit, phy_core_reset_bit;
  logic mac_side_reset_bit, system_ready_flag, sys_err_irq;
  logic [phy_rst_pkg::STRAP_W-1:0] strap_latched;
  logic [phy_rst_pkg::SYS_ERR_W-1:0] system_irq_flags;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  logic all_ok;

  phy_reset_sequencer #(.HW_RELEASE_CYC(HW_REL), .SW_RELEASE_CYC(SW_REL),
    .REF_HW_HOLD_CYC(REF_HW), .REF_SW_HOLD_CYC(REF_SW)) dut_u (.clk(clk), .rstn(rstn),
    .reset_pin_n(reset_pin_n), .power_good(power_good), .osc_stable(osc_stable),
    .pll_locked(pll_locked), .strap_pins(strap_pins), .soft_reset_wr(soft_reset_wr),
    .phy_core_reset_wr(phy_core_reset_wr), .mac_side_reset_wr(mac_side_reset_wr),
    .sys_err_events(sys_err_events), .system_irq_enables(system_irq_enables),
    .io_oe(io_oe), .strap_latched(strap_latched), .clocks_gated(clocks_gated),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .logic_reset_n(logic_reset_n),
    .regs_accessible(regs_accessible), .ref_clock_out_en(ref_clock_out_en),
    .mac_pins_low(mac_pins_low), .chip_soft_reset_bit(chip_soft_reset_bit),
    .phy_core_reset_bit(phy_core_reset_bit), .mac_side_reset_bit(mac_side_reset_bit),
    .system_ready_flag(system_ready_flag), .system_irq_flags(system_irq_flags),
    .sys_err_irq(sys_err_irq));

  clock_source_model clk_src_u (.clk(clk), .osc_enable(osc_enable),
    .pll_enable(pll_enable), .osc_stable(osc_stable), .pll_locked(pll_locked));

  // ----------------------------------------------------------------
  // Clock, timeout and helper tasks
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic tick(input int k = 1);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready(input int lim, output int cnt);
    cnt = 0;
    while (system_ready_flag !== 1'b1 && cnt < lim) begin
      tick();
      cnt = cnt + 1;
    end
  endtask

  task automatic close_out();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    rstn = 1'b1;
    tick(50);
    chk(system_ready_flag, 1'b0);
    chk(osc_enable, 1'b0);
    chk(io_oe, 1'b1);
    chk(strap_latched, 5'h0A);
    power_good = 1'b1;
    wait_ready(HW_REL, n);
    chk(n < HW_REL, 1'b1);
    chk({logic_reset_n, regs_accessible, ref_clock_out_en, pll_enable}, 4'hF);
    chk(mac_pins_low, 1'b0);
    // Short low pulse on the pin is filtered
    reset_pin_n = 1'b0;
    tick(150);
    reset_pin_n = 1'b1;
    tick(10);
    chk({system_ready_flag, io_oe}, 2'h3);
    // Sticky error flags
    system_irq_enables = 4'h1;
    sys_err_events = 4'h5;
    tick();
    sys_err_events = 4'h0;
    tick();
    chk({system_irq_flags, sys_err_irq}, 5'h0B);
    system_irq_enables = 4'h2;
    tick();
    chk(sys_err_irq, 1'b0);
    // Software reset with new straps
    strap_pins = 5'h15;
    soft_reset_wr = 1'b1;
    tick();
    soft_reset_wr = 1'b0;
    tick();
    chk({chip_soft_reset_bit, system_ready_flag, io_oe}, 3'h4);
    chk({mac_pins_low, ref_clock_out_en, logic_reset_n}, 3'h4);
    wait_ready(SW_REL + 10, n);
    chk(n < SW_REL + 10, 1'b1);
    chk(ref_clock_out_en, 1'b1);
    chk(chip_soft_reset_bit, 1'b0);
    chk(strap_latched, 5'h15);
    chk(system_irq_flags, 4'h5);
    // Self-clearing short resets, PHY core then MAC side
    for (int k = 0; k < 2; k++) begin
      if (k == 0) phy_core_reset_wr = 1'b1;
      else mac_side_reset_wr = 1'b1;
      tick();
      phy_core_reset_wr = 1'b0;
      mac_side_reset_wr = 1'b0;
      n = 0;
      all_ok = 1'b1;
      while (((k == 0) ? phy_core_reset_bit : mac_side_reset_bit) === 1'b1 && n < 300) begin
        all_ok = all_ok & regs_accessible & mac_pins_low & system_ready_flag;
        n = n + 1;
        tick();
      end
      chk(n, 240);
      chk(all_ok, 1'b1);
      chk(mac_pins_low, 1'b0);
    end
    // Hardware pin reset held for ten microseconds
    reset_pin_n = 1'b0;
    tick(2000);
    chk({clocks_gated, io_oe, regs_accessible, osc_enable}, 4'h8);
    chk(ref_clock_out_en, 1'b0);
    chk(system_irq_flags, 4'h0);
    reset_pin_n = 1'b1;
    wait_ready(HW_REL + 10, n);
    chk(n < HW_REL + 10, 1'b1);
    chk(ref_clock_out_en, 1'b1);
    chk(clocks_gated, 1'b0);
    close_out();
  end
endmodule
